// file: scd_config_decode.sv
//
// Contract
// - every visible register lives in one port
// - system address is port base plus offset
// - upstream port space based at 0x0000
// - downstream ports based at 0x2000 and 0x4000
// - undefined offsets read as zero
// - undefined writes complete, change nothing
// - switch control, status, test only upstream
// - msi capability only in downstream ports
// - hot reset bit resets whole switch
// - full reset, link bits, retrain are deferred
// - completion goes out before the action
// - action starts 1 ms after completion
// - link control word at offset 0x050
//
`timescale 1ns/10ps
module scd_config_decode #(
  parameter int unsigned DEFER_CYCLES = scd_pkg::DEFER_CYCLES_DFLT
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              srst,
  // avalon-mm slave
  input  wire logic [scd_pkg::ADDR_W-1:0]        avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [scd_pkg::DATA_W-1:0]        avs_writedata,
  input  wire logic [3:0]                        avs_byteenable,
  output logic      [scd_pkg::DATA_W-1:0]        avs_readdata,
  output logic                                   avs_waitrequest,
  // deferred actions
  output logic                                   hot_reset_pulse,
  output logic                                   full_reset_pulse,
  output logic      [scd_pkg::NUM_PORTS-1:0]     link_retrain_pulse,
  output logic      [scd_pkg::NUM_PORTS-1:0]     full_link_retrain_pulse,
  output logic      [scd_pkg::NUM_PORTS-1:0]     link_disable,
  output logic                                   deferral_pending
);
  import scd_pkg::*;

  // ****************************************
  // address decode
  // ****************************************
  logic [OFS_W-1:0]     offset;
  logic [NUM_PORTS-1:0] port_hit;
  logic [NUM_PORTS-1:0] hit_link;
  logic [NUM_PORTS-1:0] hit_phy;
  logic [NUM_PORTS-1:0] hit_msi;
  logic                 hit_switch_control_reg;
  logic                 hit_swsts;
  logic                 hit_test;
  logic                 hit_any;
  logic                 wait_reg;
  logic                 wr_acc;
  logic                 rd_acc;

  assign offset  = {avs_address[OFS_W-1:2], 2'b00};
  assign wr_acc  = avs_write && !wait_reg;
  assign rd_acc  = avs_read && !wait_reg;
  assign hit_any = |{hit_link, hit_phy, hit_msi, hit_switch_control_reg, hit_swsts,
                     hit_test};

  // ****************************************
  // per-port registers
  // ****************************************
  logic [NUM_PORTS-1:0][15:0]       link_ctl_reg;
  logic [NUM_PORTS-1:0]             msi_en_reg;
  logic [NUM_PORTS-1:0][DATA_W-1:0] port_rdata;
  logic [31:0]                      test_mode_reg;
  logic [DATA_W-1:0]                rdata_mux;
  logic                             sw_rst_fire;
  logic [ACT_W-1:0]                 act_word;
  logic                             link_wr_lo;

  scd_defer_if dif ();

  assign link_wr_lo = wr_acc && avs_byteenable[0];

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [DATA_W-1:0] msi_word;
      // base high bits select the port, one space per port
      assign port_hit[p] = avs_address[ADDR_W-1:OFS_W] ==
                           PORT_BASE[p][ADDR_W-1:OFS_W];
      assign hit_link[p] = port_hit[p] && offset == LINK_CTL_OFS;
      assign hit_phy[p]  = port_hit[p] && offset == PHY_STATE_OFS;
      if (p == 0) begin : g_up
        assign hit_msi[p] = 1'b0;
        assign msi_word   = '0;
      end else begin : g_dn
        assign hit_msi[p] = port_hit[p] && offset == MSI_CAP_OFS;
        assign msi_word   = {15'h0000, msi_en_reg[p], 8'h00, MSI_CAP_ID};
      end
      assign port_rdata[p] =
        hit_link[p] ? {16'h0000, link_ctl_reg[p]} :
        hit_msi[p]  ? msi_word : '0;

      // retrain is a trigger, it never reads back
      always_ff @(posedge clk) begin
        if (srst || sw_rst_fire) begin
          link_ctl_reg[p] <= LINK_CTL_RST;
        end else if (wr_acc && hit_link[p]) begin
          if (avs_byteenable[0]) begin
            link_ctl_reg[p][7:0] <= avs_writedata[7:0] &
                                    ~(8'h01 << LINK_RETRAIN_BIT);
          end
          if (avs_byteenable[1]) begin
            link_ctl_reg[p][15:8] <= avs_writedata[15:8];
          end
        end
      end

      always_ff @(posedge clk) begin
        if (srst || sw_rst_fire) begin
          msi_en_reg[p] <= 1'b0;
        end else if (wr_acc && hit_msi[p] && avs_byteenable[2]) begin
          msi_en_reg[p] <= avs_writedata[MSI_ENABLE_BIT];
        end
      end

      // side-effect fields go to the deferral timer, not straight out
      assign act_word[ACT_RET_LSB+p] = link_wr_lo && hit_link[p] &&
        avs_writedata[LINK_RETRAIN_BIT];
      assign act_word[ACT_FLR_LSB+p] = link_wr_lo && hit_phy[p] &&
        avs_writedata[FULL_RETRAIN_BIT];
      assign act_word[ACT_UPD_LSB+p] = link_wr_lo && hit_link[p];
      // value bit carries the disable bit; any lane-0 link control write starts the timer
      assign act_word[ACT_VAL_LSB+p] = link_wr_lo && hit_link[p] &&
        avs_writedata[LINK_DISABLE_BIT];
    end
  endgenerate

  // ****************************************
  // upstream-only global registers
  // ****************************************
  assign hit_switch_control_reg = port_hit[0] && offset == SW_CTL_OFS;
  assign hit_swsts = port_hit[0] && offset == SW_STS_OFS;
  assign hit_test  = port_hit[0] && offset == TEST_MODE_OFS;

  assign act_word[ACT_HOT]  = link_wr_lo && hit_switch_control_reg &&
                              avs_writedata[HOT_RESET_BIT];
  assign act_word[ACT_FULL] = link_wr_lo && hit_switch_control_reg &&
                              avs_writedata[FULL_RESET_BIT];

  // completion and timer start share the accepting edge
  assign dif.start   = |act_word;
  assign dif.actions = act_word;
  assign sw_rst_fire = dif.fire &&
    (dif.fire_actions[ACT_HOT] || dif.fire_actions[ACT_FULL]);

  always_ff @(posedge clk) begin
    if (srst || sw_rst_fire) begin
      test_mode_reg <= TEST_MODE_RST;
    end else if (wr_acc && hit_test) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          test_mode_reg[8*b +: 8] <= avs_writedata[8*b +: 8];
        end
      end
    end
  end

  // undefined offsets fall through every term and yield zero
  always_comb begin
    rdata_mux = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      rdata_mux = rdata_mux | port_rdata[i];
    end
    if (hit_test) begin
      rdata_mux = test_mode_reg;
    end
    if (hit_swsts) begin
      rdata_mux = '0;
      rdata_mux[STS_PENDING_BIT] = dif.pending;
      rdata_mux[STS_LINK_DISABLE_BIT_LSB +: NUM_PORTS] = link_disable;
    end
  end

  // ****************************************
  // avalon handshake, one wait state
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_reg     <= 1'b1;
      avs_readdata <= '0;
    end else begin
      wait_reg     <= !((avs_read || avs_write) && wait_reg);
      avs_readdata <= rdata_mux;
    end
  end
  assign avs_waitrequest = wait_reg;

  scd_defer_timer #(
    .DEFER_CYCLES (DEFER_CYCLES)
  ) u_timer (
    .clk  (clk),
    .srst (srst),
    .dif  (dif)
  );

  // ****************************************
  // action outputs
  // ****************************************
  // late completions are the root's problem once the action runs
  always_ff @(posedge clk) begin
    if (srst) begin
      hot_reset_pulse         <= 1'b0;
      full_reset_pulse        <= 1'b0;
      link_retrain_pulse      <= '0;
      full_link_retrain_pulse <= '0;
      link_disable            <= '0;
      deferral_pending        <= 1'b0;
    end else begin
      hot_reset_pulse  <= dif.fire && dif.fire_actions[ACT_HOT];
      full_reset_pulse <= dif.fire && dif.fire_actions[ACT_FULL];
      link_retrain_pulse <= dif.fire ?
        dif.fire_actions[ACT_RET_LSB +: NUM_PORTS] : '0;
      full_link_retrain_pulse <= dif.fire ?
        dif.fire_actions[ACT_FLR_LSB +: NUM_PORTS] : '0;
      // pending drops with the action so status and outputs agree
      deferral_pending <= dif.pending && !dif.fire;
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (sw_rst_fire) begin
          link_disable[i] <= 1'b0;
        end else if (dif.fire && dif.fire_actions[ACT_UPD_LSB+i]) begin
          link_disable[i] <= dif.fire_actions[ACT_VAL_LSB+i];
        end
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic [31:0] since_start;
  always_ff @(posedge clk) begin
    if (srst || dif.start) begin
      since_start <= '0;
    end else if (dif.pending) begin
      since_start <= since_start + 32'd1;
    end
  end

  ack_time_a: assert property ((avs_read || avs_write) && wait_reg
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not one wait state");
  rd_undef_zero_a: assert property (rd_acc && !hit_any
    |-> avs_readdata == '0)
    else $error("undefined read not zero");
  wr_undef_keep_a: assert property (wr_acc && !hit_any
    |-> !dif.start ##1 $stable(link_ctl_reg) && $stable(test_mode_reg)
        && $stable(msi_en_reg))
    else $error("undefined write changed state");
  up_only_a: assert property (rd_acc && !port_hit[0] &&
    (offset == TEST_MODE_OFS || offset == SW_STS_OFS)
    |-> avs_readdata == '0)
    else $error("global register seen downstream");
  msi_down_a: assert property (rd_acc && port_hit[0] &&
    offset == MSI_CAP_OFS |-> avs_readdata == '0)
    else $error("msi structure seen upstream");
  compl_first_a: assert property (dif.start
    |-> wr_acc && !hot_reset_pulse ##1 !hot_reset_pulse)
    else $error("action not after completion");
  defer_time_a: assert property (dif.fire
    |-> since_start == DEFER_CYCLES - 1)
    else $error("deferral time wrong");
  fire_once_a: assert property (dif.fire && !dif.start
    |=> !dif.pending && !dif.fire)
    else $error("deferred action fired twice");
  link_ctl_wr_a: assert property (wr_acc && hit_link[2] &&
    avs_byteenable[1] && !sw_rst_fire
    |=> link_ctl_reg[2][15:8] == $past(avs_writedata[15:8]))
    else $error("port two link control not written");
  pulse_one_a: assert property (hot_reset_pulse || full_reset_pulse
    |=> !hot_reset_pulse && !full_reset_pulse)
    else $error("reset pulse longer than one cycle");
  link_disable_bit_defer_a: assert property ($changed(link_disable)
    |-> $past(dif.fire))
    else $error("link disable changed without deferral");
  rst_clear_a: assert property (sw_rst_fire
    |=> test_mode_reg == TEST_MODE_RST && msi_en_reg == '0
        && link_ctl_reg == {NUM_PORTS{LINK_CTL_RST}})
    else $error("switch reset left state behind");
  retrain_defer_a: assert property (link_retrain_pulse != '0 ||
    full_link_retrain_pulse != '0 |-> $past(dif.fire))
    else $error("retrain pulse without deferral");
  sts_pending_a: assert property (rd_acc && hit_swsts
    |-> avs_readdata[STS_PENDING_BIT] == $past(dif.pending))
    else $error("status pending bit wrong");

  hot_cov: cover property (dif.start && act_word[ACT_HOT]);
  retrain_cov: cover property (link_retrain_pulse != '0);
  undef_rd_cov: cover property (rd_acc && !hit_any);
  full_cov: cover property (full_reset_pulse);
  merge_cov: cover property (dif.start && dif.pending);

endmodule : scd_config_decode

// file: scd_defer_if.sv
`timescale 1ns/10ps
interface scd_defer_if;
  import scd_pkg::*;
  logic             start;
  logic [ACT_W-1:0] actions;
  logic             pending;
  logic             fire;
  logic [ACT_W-1:0] fire_actions;

  modport timer (input start, actions, output pending, fire, fire_actions);
  modport ctrl  (output start, actions, input pending, fire, fire_actions);
endinterface : scd_defer_if

// file: scd_defer_timer.sv
`timescale 1ns/10ps
module scd_defer_timer #(
  parameter int unsigned DEFER_CYCLES = scd_pkg::DEFER_CYCLES_DFLT
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // deferral channel
  scd_defer_if.timer dif
);
  import scd_pkg::*;

  localparam int CNT_W = $clog2(DEFER_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(DEFER_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  scd_tstate_t      state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [ACT_W-1:0] held_reg;
  logic             expire;

  assign expire           = (state_reg == SCD_T_WAIT) && (cnt_reg == CNT_ONE)
                            && !dif.start;
  assign dif.fire         = expire;
  assign dif.fire_actions = held_reg;
  assign dif.pending      = (state_reg == SCD_T_WAIT);

  // a new trigger merges and restarts, so each request fires once
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SCD_T_IDLE;
      cnt_reg   <= '0;
      held_reg  <= '0;
    end else begin
      case (state_reg)
        SCD_T_IDLE: begin
          if (dif.start) begin
            state_reg <= SCD_T_WAIT;
            cnt_reg   <= CNT_LOAD;
            held_reg  <= dif.actions;
          end
        end
        SCD_T_WAIT: begin
          if (dif.start) begin
            cnt_reg  <= CNT_LOAD;
            held_reg <= held_reg | dif.actions;
          end else if (expire) begin
            state_reg <= SCD_T_IDLE;
            held_reg  <= '0;
          end else begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end
        end
        default: state_reg <= SCD_T_IDLE;
      endcase
    end
  end

endmodule : scd_defer_timer

// file: scd_pkg.sv
package scd_pkg;

  // ****************************************
  // bus and port map
  // ****************************************
  localparam int ADDR_W    = 15;
  localparam int DATA_W    = 32;
  localparam int NUM_PORTS = 3;
  localparam int OFS_W     = 13;
  localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] PORT_BASE =
    {15'h4000, 15'h2000, 15'h0000};

  // ****************************************
  // register offsets within a port
  // ****************************************
  localparam logic [OFS_W-1:0] LINK_CTL_OFS  = 13'h0050;
  localparam logic [OFS_W-1:0] MSI_CAP_OFS   = 13'h00C8;
  localparam logic [OFS_W-1:0] SW_CTL_OFS    = 13'h0404;
  localparam logic [OFS_W-1:0] SW_STS_OFS    = 13'h0408;
  localparam logic [OFS_W-1:0] TEST_MODE_OFS = 13'h040C;
  localparam logic [OFS_W-1:0] PHY_STATE_OFS = 13'h0410;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int HOT_RESET_BIT    = 0;
  localparam int FULL_RESET_BIT   = 1;
  localparam int LINK_DISABLE_BIT = 4;
  localparam int LINK_RETRAIN_BIT = 5;
  localparam int FULL_RETRAIN_BIT = 0;
  localparam int MSI_ENABLE_BIT   = 16;
  localparam int STS_PENDING_BIT  = 0;
  localparam int STS_LINK_DISABLE_BIT_LSB     = 1;
  localparam logic [15:0] LINK_CTL_RST  = 16'h0000;
  localparam logic [31:0] TEST_MODE_RST = 32'h0000_0000;
  localparam logic [7:0]  MSI_CAP_ID    = 8'h05;

  // ****************************************
  // deferred action word
  // ****************************************
  localparam int ACT_HOT      = 0;
  localparam int ACT_FULL     = 1;
  localparam int ACT_RET_LSB  = 2;
  localparam int ACT_FLR_LSB  = 5;
  localparam int ACT_UPD_LSB  = 8;
  localparam int ACT_VAL_LSB  = 11;
  localparam int ACT_W        = 14;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned DEFER_TIME_MS     = 1;
  localparam int unsigned CLK_FREQ_HZ       = 200000000;
  localparam int unsigned DEFER_CYCLES_DFLT =
    DEFER_TIME_MS * (CLK_FREQ_HZ / 1000);

  typedef enum logic [1:0] {
    SCD_T_IDLE = 2'b01,
    SCD_T_WAIT = 2'b10
  } scd_tstate_t;

endpackage : scd_pkg

// file: scd_root_model.sv
`timescale 1ns/10ps
module scd_root_model (
  // clock
  input  wire logic                       clk,
  // avalon-mm master side
  output logic      [scd_pkg::ADDR_W-1:0] avs_address,
  output logic                            avs_read,
  output logic                            avs_write,
  output logic      [scd_pkg::DATA_W-1:0] avs_writedata,
  output logic      [3:0]                 avs_byteenable,
  input  wire logic [scd_pkg::DATA_W-1:0] avs_readdata,
  input  wire logic                       avs_waitrequest
);
  import scd_pkg::*;

  initial begin
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = 4'h0;
  end

  // ****************************************
  // one config access
  // ****************************************
  task automatic acc(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [3:0] be,
    output logic [DATA_W-1:0] q, output bit ok);
    int n;
    n  = 0;
    ok = 0;
    q  = '0;
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    while (n < 50 && !ok) begin
      @(posedge clk);
      n++;
      // completion taken at the first edge it shows
      if (avs_waitrequest === 1'b0) begin
        ok = 1;
        q  = avs_readdata;
      end
    end
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    // released lines must not keep looking like a live request
    avs_address    <= ~a;
    avs_writedata  <= ~d;
  endtask : acc
endmodule : scd_root_model

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import scd_pkg::*;
  // short deferral keeps the run brief
  localparam int unsigned D = 20;
  logic              clk;
  logic              srst;
  logic [ADDR_W-1:0] adr;
  logic              rd_s;
  logic              wr_s;
  logic [DATA_W-1:0] wdat;
  logic [3:0]        be;
  logic [DATA_W-1:0] rdat;
  logic              wait_s;
  logic              hot;
  logic              full;
  logic [2:0]        link_retrain_bit;
  logic [2:0]        full_link_retrain_field;
  logic [2:0]        link_disable_bit;
  logic              pend;
  logic [8:0]        fired;
  int                bad_count;
  int                num_checks;

  assign fired = {hot, full, link_retrain_bit, full_link_retrain_field, pend};

  scd_config_decode #(.DEFER_CYCLES(D)) uut (
    .clk(clk), .srst(srst), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wait_s),
    .hot_reset_pulse(hot), .full_reset_pulse(full),
    .link_retrain_pulse(link_retrain_bit), .full_link_retrain_pulse(full_link_retrain_field),
    .link_disable(link_disable_bit), .deferral_pending(pend));

  scd_root_model root (
    .clk(clk), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_s));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [ADDR_W-1:0] ad(int p, logic [OFS_W-1:0] o);
    return PORT_BASE[p] + {2'b00, o};
  endfunction : ad

  task automatic acc(logic w, logic [ADDR_W-1:0] a, logic [31:0] d,
    logic [3:0] b, output logic [31:0] q);
    bit ok;
    root.acc(w, a, d, b, q, ok);
    if (!ok) begin
      bad_count++;
      give_verdict();
    end
  endtask : acc

  // cycles from completion until the pending flag drops
  task automatic settle(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1) chk(pend, 1'b1);
    end while (pend === 1'b1 && n < 4 * D);
    if (n >= 4 * D) begin
      bad_count++;
      give_verdict();
    end
  endtask : settle

  task automatic quiet(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
      chk(fired, 9'h000);
    end
  endtask : quiet

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_ports;
    logic [31:0] q;
    logic [2:0]  e;
    int          n;
    e = 3'b000;
    for (int p = 0; p < NUM_PORTS; p++) begin
      acc(1'b1, ad(p, LINK_CTL_OFS), 32'h0A10, 4'h3, q);
      settle(n);
      e[p] = 1'b1;
      chk(n, D);
      chk(link_disable_bit, e);
      acc(1'b0, ad(p, LINK_CTL_OFS), 32'h0, 4'hF, q);
      chk(q[15:0], 16'h0A10);
    end
    acc(1'b0, ad(0, SW_STS_OFS), 32'h0, 4'hF, q);
    chk(q[3:1], 3'b111);
  endtask : t_ports

  task automatic t_space;
    logic [31:0] q;
    acc(1'b1, ad(0, TEST_MODE_OFS), 32'hA5C3_5A3C, 4'hF, q);
    for (int p = 1; p < NUM_PORTS; p++) begin
      acc(1'b0, ad(p, TEST_MODE_OFS), 32'h0, 4'hF, q);
      chk(q, 32'h0);
      acc(1'b1, ad(p, MSI_CAP_OFS), 32'h0001_0000, 4'h4, q);
      acc(1'b0, ad(p, MSI_CAP_OFS), 32'h0, 4'hF, q);
      chk(q, {15'h0000, 1'b1, 8'h00, MSI_CAP_ID});
      acc(1'b1, ad(p, SW_CTL_OFS), 32'h3, 4'hF, q);
      acc(1'b1, ad(p, TEST_MODE_OFS), 32'hFFFF_FFFF, 4'hF, q);
    end
    acc(1'b0, ad(0, MSI_CAP_OFS), 32'h0, 4'hF, q);
    chk(q, 32'h0);
    acc(1'b0, 15'h6000, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    acc(1'b1, 15'h6004, 32'hFFFF_FFFF, 4'hF, q);
    // trigger bits sit in lane 0 only
    acc(1'b1, ad(0, SW_CTL_OFS), 32'h3, 4'hE, q);
    quiet(D + 4);
    acc(1'b0, ad(0, TEST_MODE_OFS), 32'h0, 4'hF, q);
    chk(q, 32'hA5C3_5A3C);
  endtask : t_space

  task automatic t_hot;
    logic [31:0] q;
    int          n;
    acc(1'b1, ad(0, SW_CTL_OFS), 32'h1, 4'hF, q);
    settle(n);
    chk(n, D);
    chk(fired, 9'h100);
    quiet(D + 4);
    chk(link_disable_bit, 3'b000);
    acc(1'b0, ad(0, TEST_MODE_OFS), 32'h0, 4'hF, q);
    chk(q, TEST_MODE_RST);
  endtask : t_hot

  task automatic t_merge;
    logic [31:0] q;
    int          n;
    acc(1'b1, ad(0, SW_CTL_OFS), 32'h2, 4'hF, q);
    acc(1'b1, ad(1, PHY_STATE_OFS), 32'h1, 4'hF, q);
    acc(1'b1, ad(2, LINK_CTL_OFS), 32'h20, 4'h1, q);
    settle(n);
    chk(n, D);
    chk(fired, {1'b0, 1'b1, 3'b100, 3'b010, 1'b0});
    quiet(D + 4);
  endtask : t_merge

  initial begin
    srst       = 1'b1;
    bad_count  = 0;
    num_checks = 0;
    repeat (7) @(posedge clk);
    #1;
    chk(wait_s, 1'b1);
    chk(fired, 9'h000);
    chk(link_disable_bit, 3'b000);
    chk(rdat, 32'h0);
    @(posedge clk);
    srst <= 1'b0;
    t_ports();
    t_space();
    t_hot();
    t_merge();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule : tb_top
